// ### design/icld_counter.sv
// Function
// RULE_01: flag count outside lower-to-upper window whenever bounds or count leave it.
// RULE_02: set underflow when counting down wraps lower bound to upper bound.
// RULE_03: clear underflow once count drops below lower plus two thirds span.
// RULE_04: set overflow when counting up wraps upper bound to lower bound.
// RULE_05: clear overflow once count rises above lower plus one third span.
// RULE_06: encoder modes count up when A leads B, down when A lags.
// RULE_07: direction invert swaps encoder up and down sense.
// RULE_08: pulse modes count up with track B low, down with B high.
// RULE_09: direction invert swaps the pulse mode track B sense.
// RULE_10: report present track B level as a status bit.
// RULE_11: differential pulse mode flags broken B wire unless check disabled.
// RULE_12: zero-pulse reset loads lower bound on each rising track C edge.
// RULE_13: latch reset acts on falling edge for polarity 0, rising for 1.
// RULE_14: latch resets happen only while latch reset enable is set.
// RULE_15: zero-pulse and latch resets give no status indication.
// RULE_16: zero-pulse and latch reset enables are never both active.
// RULE_17: reset settings take effect at once while running.
// RULE_18: preset load from command bit, track C pulse, or chosen latch edge.
// RULE_19: lower bound must stay below upper; violating bound writes rejected.
// RULE_20: default count spans zero to full width, wrapping both ways.
// RULE_21: preset sets done; no new preset until all requests drop.
//
// Local design decisions: the strobed register port and the address map.
module icld_counter #(
   parameter int CNT_W = 32
) (
   // clock and reset
   input  wire logic                          i_ref_clk,
   input  wire logic                          i_sys_rst,
   // register port
   input  wire logic [icld_pkg::ADDR_W-1:0]   i_addr,
   input  wire logic [icld_pkg::DATA_W-1:0]   i_wr_data,
   input  wire logic                          i_wr_en,
   input  wire logic                          i_rd_en,
   output logic      [icld_pkg::DATA_W-1:0]   o_rd_data,
   // field inputs
   input  wire logic                          i_track_a,
   input  wire logic                          i_track_b,
   input  wire logic                          i_track_c,
   input  wire logic                          i_track_b_open,
   input  wire logic                          i_latch,
   // position outputs
   output logic      [CNT_W-1:0]              o_count,
   output logic                               o_count_up,
   output icld_pkg::icld_status_type          o_status
);
   import icld_pkg::*;

   function automatic logic is_pulse(input logic [2:0] mode);
      case (mode)
         ICLD_CNT_DIFF: is_pulse = 1'b1;
         ICLD_CNT_TTL:  is_pulse = 1'b1;
         ICLD_CNT_OC:   is_pulse = 1'b1;
         default:       is_pulse = 1'b0;
      endcase
   endfunction

   // one or two thirds of the span, rounded down
   function automatic logic [CNT_W-1:0] frac3(
      input logic [CNT_W-1:0] span,
      input logic             two
   );
      logic [CNT_W:0] num;
      num   = two ? {span, 1'b0} : {1'b0, span};
      frac3 = CNT_W'(num / (CNT_W+1)'(3));
   endfunction

   function automatic logic [DATA_W-1:0] widen(input logic [CNT_W-1:0] v);
      widen = DATA_W'(v);
   endfunction

   icld_ctrl_type   ctrl_q,   ctrl_d;
   icld_cmd_type    cmd_q;
   icld_status_type st_q,     st_d;
   logic [CNT_W-1:0]  lower_q,  upper_q,  preset_q;
   logic [CNT_W-1:0]  count_q,  count_d;
   logic              dir_q;
   logic              a_q,      b_q,      c_q,      l_q;
   logic [DATA_W-1:0] rd_q,     rd_w;

   // register decode
   wire logic             wr_ctrl   = i_wr_en && (i_addr == ADDR_CTRL);
   wire logic             wr_cmd    = i_wr_en && (i_addr == ADDR_CMD);
   wire logic             wr_lower  = i_wr_en && (i_addr == ADDR_LOWER);
   wire logic             wr_upper  = i_wr_en && (i_addr == ADDR_UPPER);
   wire logic             wr_preset = i_wr_en && (i_addr == ADDR_PRESET);
   wire logic [CNT_W-1:0] wr_cnt    = i_wr_data[CNT_W-1:0];
   wire icld_ctrl_type    ctrl_new  = icld_ctrl_type'(i_wr_data[CTRL_W-1:0]);
   wire logic             both_en   = ctrl_new.c_rst_en
                                      && ctrl_new.latch_rst_en;
   wire logic             lower_ok  = wr_lower && (wr_cnt < upper_q); // [RULE_19]
   wire logic             upper_ok  = wr_upper && (wr_cnt > lower_q); // [RULE_19]

   // track decode
   wire logic pulse    = is_pulse(ctrl_q.mode);
   wire logic a_chg    = i_track_a ^ a_q;
   wire logic b_chg    = i_track_b ^ b_q;
   wire logic enc_step = !pulse && (a_chg ^ b_chg);
   wire logic enc_up   = a_chg ? (i_track_a ^ b_q)
                               : ~(i_track_b ^ a_q);        // [RULE_06]
   wire logic pg_step  = pulse && i_track_a && !a_q;
   wire logic pg_up    = ~i_track_b;                        // [RULE_08]
   wire logic step     = enc_step || pg_step;
   wire logic up       = (pulse ? pg_up : enc_up)
                         ^ ctrl_q.direction_invert;         // [RULE_07] [RULE_09]

   wire logic c_rise   = i_track_c && !c_q;
   wire logic l_rise   = i_latch && !l_q;
   wire logic l_fall   = !i_latch && l_q;
   wire logic l_edge   = ctrl_q.latch_pol ? l_rise : l_fall; // [RULE_13]
   wire logic zero_rst = ctrl_q.c_rst_en && c_rise;          // [RULE_12]
   wire logic latch_rst = ctrl_q.latch_rst_en && !ctrl_q.c_rst_en
                          && l_edge;                 // [RULE_14] [RULE_16]
   wire logic rst_hit  = zero_rst || latch_rst;

   // preset triggers, first one wins until all drop
   wire logic any_req  = |cmd_q;
   wire logic pre_fire = !st_q.preset_done && (cmd_q.set_cmd
                         || (cmd_q.on_c && c_rise)
                         || (cmd_q.on_latch_pos && l_rise)
                         || (cmd_q.on_latch_neg && l_fall)); // [RULE_18]

   // wrap and hysteresis thresholds
   wire logic [CNT_W-1:0] span = upper_q - lower_q;
   wire logic [CNT_W-1:0] thr1 = lower_q + frac3(span, 1'b0);
   wire logic [CNT_W-1:0] thr2 = lower_q + frac3(span, 1'b1);
   wire logic wrap_hi  = step && up && (count_q >= upper_q);
   wire logic wrap_lo  = step && !up && (count_q <= lower_q);
   wire logic plain    = !pre_fire && !rst_hit;
   wire logic uf_set   = plain && wrap_lo;                  // [RULE_02]
   wire logic of_set   = plain && wrap_hi;                  // [RULE_04]
   wire logic outside  = (count_q < lower_q) || (count_q > upper_q);

   always_comb begin
      ctrl_d = ctrl_q;
      if (wr_ctrl) begin
         ctrl_d = ctrl_new;                                 // [RULE_17]
         if (both_en) begin
            ctrl_d.c_rst_en     = ctrl_q.c_rst_en;          // [RULE_16]
            ctrl_d.latch_rst_en = ctrl_q.latch_rst_en;
         end
      end
   end

   always_comb begin
      count_d = count_q;
      if (pre_fire) begin
         count_d = preset_q;                                // [RULE_18]
      end else if (rst_hit) begin
         count_d = lower_q;                           // [RULE_12] [RULE_15]
      end else if (wrap_hi) begin
         count_d = lower_q;                           // [RULE_04] [RULE_20]
      end else if (wrap_lo) begin
         count_d = upper_q;                           // [RULE_02] [RULE_20]
      end else if (step) begin
         count_d = up ? count_q + CNT_W'(1) : count_q - CNT_W'(1);
      end
   end

   always_comb begin
      st_d = st_q;
      st_d.underflow   = uf_set
                         || (st_q.underflow && !(count_q < thr2)); // [RULE_03]
      st_d.overflow    = of_set
                         || (st_q.overflow && !(count_q > thr1));  // [RULE_05]
      st_d.count_outside_bounds = outside;                         // [RULE_01]
      st_d.track_b_level = i_track_b;                              // [RULE_10]
      st_d.broken_wire = (ctrl_q.mode == ICLD_CNT_DIFF)
                         && ctrl_q.b_check && i_track_b_open;      // [RULE_11]
      st_d.preset_done = pre_fire
                         || (st_q.preset_done && any_req);         // [RULE_21]
   end

   always_comb begin
      case (i_addr)
         ADDR_CTRL:   rd_w = DATA_W'(ctrl_q);
         ADDR_CMD:    rd_w = DATA_W'(cmd_q);
         ADDR_LOWER:  rd_w = widen(lower_q);
         ADDR_UPPER:  rd_w = widen(upper_q);
         ADDR_PRESET: rd_w = widen(preset_q);
         ADDR_COUNT:  rd_w = widen(count_q);
         ADDR_STATUS: rd_w = DATA_W'(st_q);
         default:     rd_w = '0;
      endcase
   end

   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ctrl_q   <= CTRL_RST;
         cmd_q    <= CMD_RST;
         lower_q  <= '0;
         upper_q  <= '1;                                    // [RULE_20]
         preset_q <= '0;
      end else begin
         ctrl_q <= ctrl_d;
         if (wr_cmd) begin
            cmd_q <= icld_cmd_type'(i_wr_data[CMD_W-1:0]);
         end
         if (lower_ok) begin
            lower_q <= wr_cnt;
         end
         if (upper_ok) begin
            upper_q <= wr_cnt;
         end
         if (wr_preset) begin
            preset_q <= wr_cnt;
         end
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         count_q <= '0;
         st_q    <= STATUS_RST;
         dir_q   <= 1'b1;
         a_q     <= 1'b0;
         b_q     <= 1'b0;
         c_q     <= 1'b0;
         l_q     <= 1'b0;
         rd_q    <= '0;
      end else begin
         count_q <= count_d;
         st_q    <= st_d;
         if (step) begin
            dir_q <= up;
         end
         a_q  <= i_track_a;
         b_q  <= i_track_b;
         c_q  <= i_track_c;
         l_q  <= i_latch;
         rd_q <= i_rd_en ? rd_w : '0;
      end
   end

   assign o_rd_data  = rd_q;
   assign o_count    = count_q;
   assign o_count_up = dir_q;
   assign o_status   = st_q;

   property p_outside;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      1'b1 |=> (o_status.count_outside_bounds
                == $past((count_q < lower_q) || (count_q > upper_q)));
   endproperty
   a_outside: assert property (p_outside) // [RULE_01]
      else $error("outside-bounds flag does not follow count and bounds");

   property p_uf_set;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (step && !up && count_q == lower_q && !pre_fire && !rst_hit)
      |=> (o_status.underflow && o_count == $past(upper_q));
   endproperty
   a_uf_set: assert property (p_uf_set) // [RULE_02]
      else $error("down wrap did not load upper bound and set underflow");

   property p_uf_clr;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (count_q < thr2 && !uf_set) |=> !o_status.underflow;
   endproperty
   a_uf_clr: assert property (p_uf_clr) // [RULE_03]
      else $error("underflow not cleared below two thirds");

   property p_of_set;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (step && up && count_q == upper_q && !pre_fire && !rst_hit)
      |=> (o_status.overflow && o_count == $past(lower_q));
   endproperty
   a_of_set: assert property (p_of_set) // [RULE_04]
      else $error("up wrap did not load lower bound and set overflow");

   property p_of_clr;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (count_q > thr1 && !of_set) |=> !o_status.overflow;
   endproperty
   a_of_clr: assert property (p_of_clr) // [RULE_05]
      else $error("overflow not cleared above one third");

   property p_enc_fwd;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (!pulse && !ctrl_q.direction_invert && !a_q && !b_q
       && i_track_a && !i_track_b && plain && count_q < upper_q)
      |=> (o_count == $past(count_q) + CNT_W'(1));
   endproperty
   a_enc_fwd: assert property (p_enc_fwd) // [RULE_06]
      else $error("A leading B did not count up");

   property p_enc_inv;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (!pulse && ctrl_q.direction_invert && !a_q && !b_q
       && i_track_a && !i_track_b && plain && count_q > lower_q)
      |=> (o_count == $past(count_q) - CNT_W'(1));
   endproperty
   a_enc_inv: assert property (p_enc_inv) // [RULE_07]
      else $error("inverted A lead did not count down");

   property p_pg_dir;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (pulse && !a_q && i_track_a && plain && count_q > lower_q
       && count_q < upper_q)
      |=> (o_count == ((($past(i_track_b)
                        ^ $past(ctrl_q.direction_invert)) == 1'b0)
                       ? $past(count_q) + CNT_W'(1)
                       : $past(count_q) - CNT_W'(1)));
   endproperty
   a_pg_dir: assert property (p_pg_dir) // [RULE_08]
      else $error("pulse mode direction does not follow track B");

   property p_b_level;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      1'b1 |=> (o_status.track_b_level == $past(i_track_b));
   endproperty
   a_b_level: assert property (p_b_level) // [RULE_10]
      else $error("track B level status is stale");

   property p_bw_off;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (!ctrl_q.b_check || ctrl_q.mode != ICLD_CNT_DIFF)
      |=> !o_status.broken_wire;
   endproperty
   a_bw_off: assert property (p_bw_off) // [RULE_11]
      else $error("broken wire flagged while check disabled");

   property p_zero_rst;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (ctrl_q.c_rst_en && !c_q && i_track_c && !pre_fire)
      |=> (o_count == $past(lower_q));
   endproperty
   a_zero_rst: assert property (p_zero_rst) // [RULE_12]
      else $error("zero pulse did not load lower bound");

   property p_bounds;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (wr_lower && wr_cnt >= upper_q) |=> $stable(lower_q);
   endproperty
   a_bounds: assert property (p_bounds) // [RULE_19]
      else $error("lower bound accepted at or above upper bound");

   property p_done_hold;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (o_status.preset_done && any_req)
      |=> (o_status.preset_done
           && ($stable(count_q) || $past(step) || $past(rst_hit)));
   endproperty
   a_done_hold: assert property (p_done_hold) // [RULE_21]
      else $error("preset done dropped while a request is held");

   property p_pg_inv;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (pulse && ctrl_q.direction_invert && !a_q && i_track_a && !i_track_b
       && plain && count_q > lower_q)
      |=> (o_count == $past(count_q) - CNT_W'(1));
   endproperty
   a_pg_inv: assert property (p_pg_inv) // [RULE_09]
      else $error("inverted pulse mode with track B low did not count down");

   property p_latch_rst;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (ctrl_q.latch_rst_en && !ctrl_q.c_rst_en && !pre_fire
       && (ctrl_q.latch_pol ? (i_latch && !l_q) : (!i_latch && l_q)))
      |=> (o_count == $past(lower_q));
   endproperty
   a_latch_rst: assert property (p_latch_rst) // [RULE_13]
      else $error("selected latch edge did not load lower bound");

   property p_latch_off;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (!ctrl_q.latch_rst_en && !c_rise && !step && !pre_fire
       && (i_latch != l_q))
      |=> $stable(o_count);
   endproperty
   a_latch_off: assert property (p_latch_off) // [RULE_14]
      else $error("latch edge moved the count while latch reset is off");

   property p_both_en;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      !(ctrl_q.c_rst_en && ctrl_q.latch_rst_en);
   endproperty
   a_both_en: assert property (p_both_en) // [RULE_16]
      else $error("zero pulse and latch reset enabled together");

   property p_upper_rej;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (wr_upper && wr_cnt <= lower_q) |=> $stable(upper_q);
   endproperty
   a_upper_rej: assert property (p_upper_rej) // [RULE_19]
      else $error("upper bound accepted at or below lower bound");

   property p_preset;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      pre_fire |=> (o_count == $past(preset_q) && o_status.preset_done);
   endproperty
   a_preset: assert property (p_preset) // [RULE_18]
      else $error("preset trigger did not load preset and set done");

endmodule

// ### design/icld_pkg.sv
package icld_pkg;

   // register port geometry
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;

   // register byte addresses
   localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_CMD    = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_LOWER  = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_UPPER  = 8'h0C;
   localparam logic [ADDR_W-1:0] ADDR_PRESET = 8'h10;
   localparam logic [ADDR_W-1:0] ADDR_COUNT  = 8'h14;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h18;

   // width of the writable field of the control and command words
   localparam int CTRL_W = 8;
   localparam int CMD_W  = 4;

   typedef enum logic [2:0] {
      ICLD_ENC_DIFF = 3'b000,
      ICLD_CNT_DIFF = 3'b001,
      ICLD_ENC_TTL  = 3'b010,
      ICLD_CNT_TTL  = 3'b011,
      ICLD_ENC_OC   = 3'b100,
      ICLD_CNT_OC   = 3'b101
   } icld_mode_type;

   typedef struct packed {
      logic       latch_pol;
      logic       latch_rst_en;
      logic       c_rst_en;
      logic       b_check;
      logic       direction_invert;
      logic [2:0] mode;
   } icld_ctrl_type;

   typedef struct packed {
      logic on_latch_neg;
      logic on_latch_pos;
      logic on_c;
      logic set_cmd;
   } icld_cmd_type;

   typedef struct packed {
      logic preset_done;
      logic broken_wire;
      logic track_b_level;
      logic count_outside_bounds;
      logic overflow;
      logic underflow;
   } icld_status_type;

   // values after reset
   localparam icld_ctrl_type   CTRL_RST   = icld_ctrl_type'(8'h00);
   localparam icld_cmd_type    CMD_RST    = icld_cmd_type'(4'h0);
   localparam icld_status_type STATUS_RST = icld_status_type'(6'h00);

endpackage

// ### testbench/icld_track_src.sv
module icld_track_src (
   // clock
   input  wire logic i_ref_clk,
   // field tracks
   output logic      o_track_a,
   output logic      o_track_b,
   output logic      o_track_c,
   output logic      o_track_b_open,
   output logic      o_latch
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      o_track_a      = 1'b0;
      o_track_b      = 1'b0;
      o_track_c      = 1'b0;
      o_track_b_open = 1'b0;
      o_latch        = 1'b0;
   end

   task automatic settle();
      repeat (3) @(posedge i_ref_clk);
   endtask

   // one quarter step; forward order on (a,b) is 00 10 11 01
   task automatic enc(input bit fwd);
      logic [1:0] idx;
      idx = {o_track_b, o_track_a ^ o_track_b};
      idx = fwd ? idx + 2'd1 : idx - 2'd1;
      @(posedge i_ref_clk);
      o_track_a <= idx[1] ^ idx[0];
      o_track_b <= idx[1];
      settle();
   endtask

   // direction level first, then one rising edge on track a
   task automatic pulse(input bit b);
      @(posedge i_ref_clk);
      o_track_a <= 1'b0;
      o_track_b <= b & ~o_track_b_open;
      settle();
      o_track_a <= 1'b1;
      settle();
      o_track_a <= 1'b0;
      settle();
   endtask

   task automatic c_pulse();
      @(posedge i_ref_clk);
      o_track_c <= 1'b1;
      settle();
      o_track_c <= 1'b0;
      settle();
   endtask

   task automatic set_latch(input bit v);
      @(posedge i_ref_clk);
      o_latch <= v;
      settle();
   endtask

   // an open wire reads as low level
   task automatic set_open(input bit v);
      @(posedge i_ref_clk);
      o_track_b_open <= v;
      if (v) o_track_b <= 1'b0;
      settle();
   endtask
endmodule

// ### testbench/test_incremental_counter_limits_direction.sv
module test_incremental_counter_limits_direction import icld_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int CW = 16;
   localparam logic [31:0] MASK = 32'h0000FFFF;
   logic               clk, rst, wr_en, rd_en;
   logic [ADDR_W-1:0]  addr;
   logic [DATA_W-1:0]  wr_data, rd_data;
   wire                trk_a, trk_b, trk_c, trk_bo, trk_l;
   logic [CW-1:0]      count;
   logic               count_up;
   icld_status_type    status;
   int                 n_fail, tests_run, m_cnt, m_lo, m_up, m_pre;
   bit                 m_uf, m_of, m_done, m_dir, bo;
   icld_ctrl_type      m_ctrl;
   icld_cmd_type       m_cmd;
   logic [31:0]        seed;
   logic [ADDR_W-1:0]  ra [8] = '{ADDR_CTRL, ADDR_CMD, ADDR_LOWER, ADDR_UPPER,
                                  ADDR_PRESET, ADDR_COUNT, ADDR_STATUS, 8'h1C};
   logic [31:0]        re [8] = '{0, 0, 0, 32'h0000FFFF, 0, 0, 0, 0};

   icld_counter #(.CNT_W(CW)) icld_counter_inst (
      .i_ref_clk(clk), .i_sys_rst(rst), .i_addr(addr), .i_wr_data(wr_data),
      .i_wr_en(wr_en), .i_rd_en(rd_en), .o_rd_data(rd_data),
      .i_track_a(trk_a), .i_track_b(trk_b), .i_track_c(trk_c),
      .i_track_b_open(trk_bo), .i_latch(trk_l), .o_count(count),
      .o_count_up(count_up), .o_status(status));
   icld_track_src icld_track_src_inst (
      .i_ref_clk(clk), .o_track_a(trk_a), .o_track_b(trk_b),
      .o_track_c(trk_c), .o_track_b_open(trk_bo), .o_latch(trk_l));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic cmp_st(input icld_status_type e, input icld_status_type g);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("Error status expected %h seen %h", e, g);
      end
   endtask

   // flags drop on the hysteresis thresholds of the current count
   task automatic m_clear();
      int span;
      span = m_up - m_lo;
      if (m_cnt < m_lo + (2 * span) / 3) m_uf = 1'b0;
      if (m_cnt > m_lo + span / 3) m_of = 1'b0;
   endtask

   task automatic m_step(input bit up);
      m_clear();
      if (up && m_cnt >= m_up) begin
         m_cnt = m_lo;
         m_of  = 1'b1;
      end else if (up) m_cnt++;
      else if (m_cnt <= m_lo) begin
         m_cnt = m_up;
         m_uf  = 1'b1;
      end else m_cnt--;
      m_dir = up;
      m_clear();
   endtask

   task automatic m_load(input int v);
      m_cnt = v;
      m_clear();
   endtask

   task automatic m_edge(input bit src_c, input bit rise);
      if (!m_done && (src_c ? m_cmd.on_c : (rise ? m_cmd.on_latch_pos
                                                 : m_cmd.on_latch_neg))) begin
         m_load(m_pre);
         m_done = 1'b1;
      end else if (src_c ? m_ctrl.c_rst_en : (m_ctrl.latch_rst_en &&
                   !m_ctrl.c_rst_en && m_ctrl.latch_pol == rise)) begin
         m_load(m_lo);
      end
   endtask

   task automatic chk();
      icld_status_type e;
      #1;
      e.underflow            = m_uf;
      e.overflow             = m_of;
      e.count_outside_bounds = (m_cnt < m_lo) || (m_cnt > m_up);
      e.track_b_level        = trk_b;
      e.broken_wire          = m_ctrl.mode == 3'd1 && m_ctrl.b_check && trk_bo;
      e.preset_done          = m_done;
      cmp("count", 32'(m_cnt), 32'(count));
      cmp("count_up", 32'(m_dir), 32'(count_up));
      cmp_st(e, status);
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge clk);
      wr_en   <= 1'b1;
      addr    <= a;
      wr_data <= d;
      @(posedge clk);
      wr_en <= 1'b0;
      repeat (2) @(posedge clk);
      case (a)
         ADDR_LOWER:  if (int'(d) < m_up) m_lo = d;
         ADDR_UPPER:  if (int'(d) > m_lo) m_up = d;
         ADDR_PRESET: m_pre = d;
         ADDR_CTRL:   m_ctrl = (d[5] && d[6]) ? icld_ctrl_type'({d[7],
                         m_ctrl.latch_rst_en, m_ctrl.c_rst_en, d[4:0]})
                         : icld_ctrl_type'(d[7:0]);
         ADDR_CMD: begin
            m_cmd = icld_cmd_type'(d[3:0]);
            if (d[0] && !m_done) begin
               m_load(m_pre);
               m_done = 1'b1;
            end
            if (d[3:0] == 4'h0) m_done = 1'b0;
         end
         default: ;
      endcase
      m_clear();
   endtask

   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
      @(posedge clk);
      rd_en <= 1'b1;
      addr  <= a;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      cmp("rd_data", e, rd_data & MASK);
   endtask

   task automatic step(input bit r);
      bit up;
      if (m_ctrl.mode[0]) begin
         icld_track_src_inst.pulse(r);
         up = !trk_b;
      end else begin
         icld_track_src_inst.enc(r);
         up = r;
      end
      m_step(up ^ m_ctrl.direction_invert);
      chk();
   endtask

   initial begin
      #1_000_000;
      n_fail++;
      report_and_stop();
   end

   initial begin
      seed = 32'hD5DA;
      n_fail = 0;
      tests_run = 0;
      rst = 1'b1;
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr = '0;
      wr_data = '0;
      {m_cnt, m_lo, m_up, m_pre} = {32'd0, 32'd0, MASK, 32'd0};
      {m_uf, m_of, m_done, m_dir} = 4'b0001;
      m_ctrl = CTRL_RST;
      m_cmd = CMD_RST;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      chk();
      for (int i = 0; i < 8; i++) rd_chk(ra[i], re[i]);
      step(1'b0);
      step(1'b1);
      wr(ADDR_UPPER, 30);
      wr(ADDR_LOWER, 6);
      wr(ADDR_LOWER, 40);
      wr(ADDR_UPPER, 3);
      wr(ADDR_COUNT, 5);
      rd_chk(ADDR_LOWER, 6);
      rd_chk(ADDR_UPPER, 30);
      chk();
      wr(ADDR_PRESET, 28);
      wr(ADDR_CMD, 1);
      chk();
      wr(ADDR_PRESET, 9);
      wr(ADDR_CMD, 3);
      icld_track_src_inst.c_pulse();
      m_edge(1'b1, 1'b1);
      chk();
      wr(ADDR_CMD, 0);
      chk();
      repeat (30) step(1'b1);
      repeat (30) step(1'b0);
      for (int m = 0; m < 6; m++) begin
         for (int v = 0; v < 2; v++) begin
            wr(ADDR_CTRL, {27'h0, v[0], v[0], m[2:0]});
            repeat (6) step(1'(xs()));
            bo = trk_b;
            icld_track_src_inst.set_open(1'(xs()) | m[0]);
            if (!m[0] && bo && !trk_b)
               m_step(!trk_a ^ m_ctrl.direction_invert);
            chk();
            if (m[0]) step(1'b1);
            icld_track_src_inst.set_open(1'b0);
            chk();
         end
      end
      wr(ADDR_CTRL, 32'h20);
      step(1'b1);
      icld_track_src_inst.c_pulse();
      m_edge(1'b1, 1'b1);
      chk();
      wr(ADDR_CTRL, 32'h60);
      rd_chk(ADDR_CTRL, 32'h20);
      for (int k = 0; k < 4; k++) begin
         wr(ADDR_CTRL, {24'h0, k[1], k[0], 6'h0});
         step(1'b1);
         icld_track_src_inst.set_latch(1'b1);
         m_edge(1'b0, 1'b1);
         chk();
         icld_track_src_inst.set_latch(1'b0);
         m_edge(1'b0, 1'b0);
         chk();
      end
      wr(ADDR_CTRL, 0);
      for (int k = 1; k < 4; k++) begin
         wr(ADDR_PRESET, 32'(7 + xs() % 20));
         wr(ADDR_CMD, 32'(1 << k));
         if (k == 1) begin
            icld_track_src_inst.c_pulse();
            m_edge(1'b1, 1'b1);
         end else begin
            icld_track_src_inst.set_latch(1'b1);
            m_edge(1'b0, 1'b1);
            chk();
            icld_track_src_inst.set_latch(1'b0);
            m_edge(1'b0, 1'b0);
         end
         chk();
         wr(ADDR_CMD, 0);
         chk();
      end
      report_and_stop();
   end
endmodule
